/* File: core/fesc_host.sv */
`timescale 1ns/100ps
`default_nettype none
module fesc_host
  import fesc_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // User command port
  input  wire logic        i_cmd_valid,
  input  wire fesc_cmd_t   i_cmd,
  input  wire logic [19:0] i_addr,
  input  wire logic [15:0] i_data,
  input  wire logic        i_op_done,
  output logic             o_cmd_ready,
  output logic             o_cmd_err,
  output logic             o_rd_valid,
  output logic [15:0]      o_rd_data,
  output fesc_mode_t       o_mode,
  // Flash pins
  output logic [19:0]      o_addr,
  output logic [15:0]      o_dq_out,
  output logic             o_dq_oe,
  input  wire logic [15:0] i_dq_in,
  output logic             o_ce_n,
  output logic             o_we_n,
  output logic             o_oe_n
);

  typedef struct packed {
    fesc_phase_t      phase;
    fesc_cmd_t        cmd;
    logic [19:0]      uaddr;
    logic [15:0]      udata;
    logic [2:0]       step;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] add_cnt;
    fesc_mode_t       mode;
    logic             susp;
    logic             ready;
    logic             err;
    logic             rd_valid;
    logic [15:0]      rd_data;
    logic [19:0]      addr;
    logic [15:0]      dq_out;
    logic             dq_oe;
    logic             ce_n;
    logic             we_n;
    logic             oe_n;
  } fesc_state_t;

  fesc_state_t q, d;

  function automatic logic [2:0] cmd_len(input fesc_cmd_t c);
    case (c)
      C_READ, C_RESET, C_SECT_ADD, C_SUSPEND, C_RESUME, C_QUERY: cmd_len = 3'd1;
      C_BYP_PROG, C_BYP_EXIT:                                    cmd_len = 3'd2;
      C_SEC_ENTER, C_BYP_ENTER:                                  cmd_len = 3'd3;
      C_CHIP_ERASE, C_SECT_ERASE:                                cmd_len = 3'd6;
      default:                                                   cmd_len = 3'd4;
    endcase
  endfunction : cmd_len

  function automatic fesc_step_t step_of(input fesc_cmd_t c, input logic [2:0] s,
                                         input logic [19:0] a, input logic [15:0] w);
    logic [8:0] hi;
    hi = a[19:11];
    step_of = '{rd: 1'b0, addr: {hi, A_555}, data: D_UNLK1};
    if (s == 3'd1 || s == 3'd4) step_of = '{rd: 1'b0, addr: {hi, A_2AA}, data: D_UNLK2};
    case (c)
      C_READ:       step_of = '{rd: 1'b1, addr: a, data: D_ZERO};
      C_RESET:      step_of.data = D_RESET;
      C_SUSPEND:    step_of = '{rd: 1'b0, addr: a, data: D_SUSP};
      C_RESUME:     step_of = '{rd: 1'b0, addr: a, data: D_SECT};
      C_SECT_ADD:   step_of = '{rd: 1'b0, addr: a, data: D_SECT};
      C_QUERY:      step_of = '{rd: 1'b0, addr: {hi, A_QRY}, data: D_QUERY};
      C_AUTOSEL: begin
        if (s == 3'd2) step_of.data = D_AUTO;
        if (s == 3'd3) step_of = '{rd: 1'b1, addr: a, data: D_ZERO};
      end
      C_SEC_ENTER:  if (s == 3'd2) step_of.data = D_SECURE;
      C_SEC_EXIT: begin
        if (s == 3'd2) step_of.data = D_AUTO;
        if (s == 3'd3) step_of = '{rd: 1'b0, addr: a, data: D_ZERO};
      end
      C_PROGRAM: begin
        if (s == 3'd2) step_of.data = D_PROG;
        if (s == 3'd3) step_of = '{rd: 1'b0, addr: a, data: w};
      end
      C_BYP_ENTER:  if (s == 3'd2) step_of.data = D_BYPASS;
      C_BYP_PROG:   step_of = '{rd: 1'b0, addr: a, data: (s == 3'd0) ? D_PROG : w};
      C_BYP_EXIT:   step_of = '{rd: 1'b0, addr: a, data: (s == 3'd0) ? D_AUTO : D_ZERO};
      C_CHIP_ERASE, C_SECT_ERASE: begin
        if (s == 3'd2) step_of.data = D_ESETUP;
        if (s == 3'd5) step_of = '{rd: 1'b0, addr: (c == C_CHIP_ERASE) ? {hi, A_555} : a,
                                   data: (c == C_CHIP_ERASE) ? D_CHIP : D_SECT};
      end
      default: step_of.data = D_ZERO;
    endcase
  endfunction : step_of

  // Refusing commands the bank would ignore keeps the tracked mode honest.
  function automatic logic legal(input fesc_cmd_t c, input fesc_mode_t m,
                                 input logic [CNT_W-1:0] ac);
    case (c)
      C_READ:       legal = 1'b1;
      C_RESET:      legal = (m != M_BYPASS) && (m != M_ERASE) && (m != M_CHIP);
      C_AUTOSEL:    legal = (m == M_ARRAY) || (m == M_SUSP);
      C_SEC_ENTER, C_BYP_ENTER, C_CHIP_ERASE, C_SECT_ERASE: legal = (m == M_ARRAY);
      C_SEC_EXIT:   legal = (m == M_SECURE);
      C_PROGRAM:    legal = (m == M_ARRAY) || (m == M_SUSP) || (m == M_SECURE);
      C_BYP_PROG, C_BYP_EXIT: legal = (m == M_BYPASS);
      C_SECT_ADD:   legal = (m == M_ERASE) && (ac < ADD_CYC);
      C_SUSPEND:    legal = (m == M_ERASE);
      C_RESUME:     legal = (m == M_SUSP);
      C_QUERY:      legal = (m == M_ARRAY) || (m == M_AUTOSEL);
      default:      legal = 1'b0;
    endcase
  endfunction : legal

  fesc_step_t cur;
  logic       accept;
  logic       last;

  always_comb begin
    cur    = step_of(q.cmd, q.step, q.uaddr, q.udata);
    accept = (q.phase == P_IDLE) && q.ready && i_cmd_valid && legal(i_cmd, q.mode, q.add_cnt);
    last   = (q.step == cmd_len(q.cmd) - STEP_ONE);
    d          = q;
    d.err      = 1'b0;
    d.rd_valid = 1'b0;
    if (q.add_cnt != CNT_MAX) d.add_cnt = q.add_cnt + CNT_ONE;
    if (i_op_done && (q.mode == M_ERASE || q.mode == M_CHIP)) d.mode = M_ARRAY;
    case (q.phase)
      P_IDLE: begin
        if (q.ready && i_cmd_valid) begin
          d.err = !accept;
          if (accept) begin
            d.cmd   = i_cmd;
            d.uaddr = i_addr;
            d.udata = i_data;
            d.step  = 3'd0;
            d.ready = 1'b0;
            d.phase = P_SETUP;
          end
        end
      end
      P_SETUP: begin
        d.addr   = cur.addr;
        d.ce_n   = 1'b0;
        d.dq_out = cur.data;
        d.dq_oe  = !cur.rd;
        d.oe_n   = !cur.rd;
        d.cnt    = cur.rd ? RD_CYC - CNT_ONE : WP_CYC - CNT_ONE;
        d.phase  = cur.rd ? P_READ : P_STROBE;
      end
      P_STROBE: begin
        d.we_n  = 1'b0;
        d.phase = P_LOW;
      end
      P_LOW: begin
        d.cnt = q.cnt - CNT_ONE;
        if (q.cnt == '0) begin
          d.we_n  = 1'b1;
          d.phase = P_HOLD;
        end
      end
      P_HOLD, P_READ: begin
        d.cnt = q.cnt - CNT_ONE;
        if (q.phase == P_HOLD || q.cnt == '0) begin
          // Data stays on the pins one cycle past the rising strobe as hold time.
          d.ce_n  = 1'b1;
          d.dq_oe = 1'b0;
          d.oe_n  = 1'b1;
          if (q.phase == P_READ) begin
            d.rd_data  = i_dq_in;
            d.rd_valid = 1'b1;
          end
          d.step  = q.step + STEP_ONE;
          d.phase = P_SETUP;
          if (last) begin
            d.phase = P_IDLE;
            d.ready = 1'b1;
            case (q.cmd)
              C_RESET:      d.mode = q.susp ? M_SUSP : M_ARRAY;
              C_AUTOSEL, C_QUERY: d.mode = M_AUTOSEL;
              C_SEC_ENTER:  d.mode = M_SECURE;
              C_BYP_ENTER:  d.mode = M_BYPASS;
              C_SEC_EXIT, C_BYP_EXIT: d.mode = M_ARRAY;
              C_CHIP_ERASE: d.mode = M_CHIP;
              C_SECT_ERASE, C_SECT_ADD: begin
                d.mode    = M_ERASE;
                d.add_cnt = '0;
              end
              C_SUSPEND: begin
                d.mode  = M_SUSP;
                d.susp  = 1'b1;
                d.add_cnt = CNT_MAX;
                d.cnt   = SUS_CYC - CNT_ONE;
                d.ready = 1'b0;
                d.phase = P_WAIT;
              end
              C_RESUME: begin
                d.mode = M_ERASE;
                d.susp = 1'b0;
              end
              default: d.mode = q.mode;
            endcase
          end
        end
      end
      P_WAIT: begin
        d.cnt = q.cnt - CNT_ONE;
        if (q.cnt == '0) begin
          d.ready = 1'b1;
          d.phase = P_IDLE;
        end
      end
      default: d.phase = P_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      q         <= '0;
      q.phase   <= P_IDLE;
      q.mode    <= M_ARRAY;
      q.add_cnt <= CNT_MAX;
      q.ready   <= 1'b1;
      q.ce_n    <= 1'b1;
      q.we_n    <= 1'b1;
      q.oe_n    <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign o_cmd_ready = q.ready;
  assign o_cmd_err   = q.err;
  assign o_rd_valid  = q.rd_valid;
  assign o_rd_data   = q.rd_data;
  assign o_mode      = q.mode;
  assign o_addr      = q.addr;
  assign o_dq_out    = q.dq_out;
  assign o_dq_oe     = q.dq_oe;
  assign o_ce_n      = q.ce_n;
  assign o_we_n      = q.we_n;
  assign o_oe_n      = q.oe_n;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_susp_in_erase: assert property (
    accept && i_cmd == C_SUSPEND |-> q.mode == M_ERASE
    ##3 (!o_we_n && o_dq_out == D_SUSP && o_addr == $past(i_addr, 3)))
    else $error("suspend outside erase");
  a_chip_refuses: assert property (
    q.ready && q.phase == P_IDLE && i_cmd_valid && i_cmd == C_SUSPEND && q.mode == M_CHIP
    |=> o_cmd_err && o_we_n) else $error("suspend taken in chip erase");
  a_susp_wait: assert property (
    accept && i_cmd == C_SUSPEND |-> ##[6:12] (q.phase == P_WAIT && q.cnt == SUS_CYC - CNT_ONE))
    else $error("suspend latency not started");
  a_resume_susp: assert property (
    accept && i_cmd == C_RESUME |-> q.mode == M_SUSP ##[6:12] o_mode == M_ERASE)
    else $error("resume outside suspend");
  a_query_mode: assert property (
    accept && i_cmd == C_QUERY |-> (q.mode == M_ARRAY || q.mode == M_AUTOSEL)
    ##3 (!o_we_n && o_dq_out == D_QUERY && o_addr[10:0] == A_QRY))
    else $error("query in wrong mode");
  a_prog_susp: assert property (
    accept && i_cmd == C_PROGRAM && q.mode == M_SUSP && !i_op_done
    |-> ##[20:40] (o_cmd_ready && o_mode == M_SUSP)) else $error("program left suspend");
  a_we_width: assert property (
    $fell(o_we_n) |-> !o_we_n [*2] ##1 o_we_n) else $error("write pulse width wrong");
  a_data_driven: assert property (
    !o_we_n |-> o_dq_oe && !o_ce_n && $stable(o_addr) && $stable(o_dq_out))
    else $error("pins move during write strobe");
  a_add_window: assert property (
    accept && i_cmd == C_SECT_ADD |-> q.add_cnt < ADD_CYC) else $error("late sector add");
  a_reset_back: assert property (
    accept && i_cmd == C_RESET && q.susp |-> ##[6:12] o_mode == M_SUSP)
    else $error("reset lost suspend");

  c_suspend: cover property (accept && i_cmd == C_SUSPEND);
  c_resume: cover property (accept && i_cmd == C_RESUME);
  c_autosel_read: cover property (o_rd_valid && q.cmd == C_AUTOSEL);
  c_sect_add: cover property (accept && i_cmd == C_SECT_ADD);

endmodule : fesc_host
`default_nettype wire

/* File: core/fesc_pkg.sv */
package fesc_pkg;

  // Bus cycle timing at 50 MHz.
  localparam int unsigned CLK_NS   = 20;
  localparam int unsigned T_WP_NS  = 40;
  localparam int unsigned T_ACC_NS = 70;
  localparam int unsigned T_SUS_US = 20;
  localparam int unsigned T_ADD_US = 50;
  localparam int unsigned CNT_W    = 12;
  localparam logic [CNT_W-1:0] WP_CYC  = CNT_W'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] RD_CYC  = CNT_W'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] SUS_CYC = CNT_W'((T_SUS_US * 1000 + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] ADD_CYC = CNT_W'((T_ADD_US * 1000) / CLK_NS);

  // Command codes and fixed unlock addresses.
  localparam logic [15:0] D_UNLK1  = 16'h00AA;
  localparam logic [15:0] D_UNLK2  = 16'h0055;
  localparam logic [15:0] D_AUTO   = 16'h0090;
  localparam logic [15:0] D_SECURE = 16'h0088;
  localparam logic [15:0] D_PROG   = 16'h00A0;
  localparam logic [15:0] D_BYPASS = 16'h0020;
  localparam logic [15:0] D_ESETUP = 16'h0080;
  localparam logic [15:0] D_CHIP   = 16'h0010;
  localparam logic [15:0] D_SECT   = 16'h0030;
  localparam logic [15:0] D_SUSP   = 16'h00B0;
  localparam logic [15:0] D_RESET  = 16'h00F0;
  localparam logic [15:0] D_QUERY  = 16'h0098;
  localparam logic [15:0] D_ZERO   = 16'h0000;
  localparam logic [10:0] A_555    = 11'h555;
  localparam logic [10:0] A_2AA    = 11'h2AA;
  localparam logic [10:0] A_QRY    = 11'h055;
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
  localparam logic [2:0]  STEP_ONE = 3'h1;

  typedef enum logic [3:0] {
    C_READ, C_RESET, C_AUTOSEL, C_SEC_ENTER, C_SEC_EXIT, C_PROGRAM, C_BYP_ENTER,
    C_BYP_PROG, C_BYP_EXIT, C_CHIP_ERASE, C_SECT_ERASE, C_SECT_ADD, C_SUSPEND,
    C_RESUME, C_QUERY
  } fesc_cmd_t;

  typedef enum logic [2:0] {
    M_ARRAY, M_AUTOSEL, M_SECURE, M_BYPASS, M_ERASE, M_CHIP, M_SUSP
  } fesc_mode_t;

  typedef enum logic [2:0] {
    P_IDLE, P_SETUP, P_STROBE, P_LOW, P_HOLD, P_READ, P_WAIT
  } fesc_phase_t;

  typedef struct packed {
    logic        rd;
    logic [19:0] addr;
    logic [15:0] data;
  } fesc_step_t;

endpackage : fesc_pkg

/* File: sim/fesc_flash_model.sv */
`timescale 1ns/100ps
`default_nettype none
module fesc_flash_model #(
  parameter logic [15:0] MAKER     = 16'h00C5,
  parameter logic [15:0] DEVID     = 16'h7E51,
  parameter logic [15:0] SEC_WORD  = 16'h5EC0,
  parameter logic [15:0] STAT_WORD = 16'h00A4,
  parameter logic [7:0]  PROT_SEC  = 8'h07
) (
  // Host side pins
  input  wire logic [19:0] i_addr,
  input  wire logic [15:0] i_dq,
  input  wire logic        i_ce_n,
  input  wire logic        i_we_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_done,
  // Read data
  output logic      [15:0] o_dq
);
  // The identity values above are arbitrary.
  localparam int ARR = 0, AUT = 1, SEC = 2, BYP = 3, ERS = 4, CHP = 5, SUS = 6;
  int          st = ARR;
  int          step = 0;
  logic        prog = 1'b0;
  logic        xit = 1'b0;
  logic        wsus = 1'b0;
  logic        win = 1'b0;
  time         tw = 0;
  logic [7:0]  esec = 8'h00;
  logic [19:0] la;
  logic [15:0] rw;
  logic [15:0] last = 16'h0000;
  logic [15:0] mem [256];

  initial foreach (mem[n]) mem[n] = 16'hFFFF;

  task automatic wr(input logic [19:0] a, input logic [15:0] w);
    logic [7:0] d;
    logic       u;
    d = w[7:0];
    u = (a[10:0] == 11'h555);
    if (prog) begin
      mem[a[7:0]] = w;
      prog = 1'b0;
    end else if (xit) begin
      xit = 1'b0;
      if (d == 8'h00) st = ARR;
    end else if (st == CHP) begin
    end else if (st == ERS) begin
      if (d == 8'hB0) begin
        st = SUS;
        win = 1'b0;
      end else if (win && ($time - tw) < 50000) begin
        // Inside the 50 us add window a further sector restarts it; anything else aborts.
        if (d == 8'h30) tw = $time;
        else begin
          st = ARR;
          win = 1'b0;
        end
      end
    end else if (st == BYP) begin
      if (d == 8'hA0) prog = 1'b1;
      else if (d == 8'h90) xit = 1'b1;
    end else if (d == 8'hF0) begin
      st = (wsus || st == SUS) ? SUS : ARR;
      wsus = 1'b0;
      step = 0;
    end else if (st == SUS && step == 0 && d == 8'h30) st = ERS;
    else if (d == 8'h98 && a[10:0] == 11'h055 && (st == ARR || st == AUT)) st = AUT;
    else case (step)
      0: step = (d == 8'hAA && u) ? 1 : 0;
      1: step = (d == 8'h55 && a[10:0] == 11'h2AA) ? 2 : 0;
      2: begin
        step = 0;
        if (u && d == 8'h90 && st == SEC) xit = 1'b1;
        else if (u && d == 8'h90) begin
          wsus = (st == SUS);
          st = AUT;
        end else if (u && d == 8'h88) st = SEC;
        else if (u && d == 8'hA0) prog = 1'b1;
        else if (u && d == 8'h20) st = BYP;
        else if (u && d == 8'h80) step = 3;
      end
      3: step = (d == 8'hAA && u) ? 4 : 0;
      4: step = (d == 8'h55 && a[10:0] == 11'h2AA) ? 5 : 0;
      default: begin
        step = 0;
        if (d == 8'h10 && u) st = CHP;
        else if (d == 8'h30) begin
          st = ERS;
          esec = a[19:12];
          tw = $time;
          win = 1'b1;
        end
      end
    endcase
  endtask : wr

  always @(negedge i_we_n) la = i_addr;
  always @(posedge i_we_n) if (!i_ce_n) wr(la, i_dq);
  always @(posedge i_done) if (st == ERS || st == CHP) st = ARR;

  always_comb begin
    if (st == AUT && i_addr[7:0] == 8'h00) rw = MAKER;
    else if (st == AUT && i_addr[7:0] == 8'h01) rw = DEVID;
    else if (st == AUT && i_addr[7:0] == 8'h03) rw = 16'h0080;
    else if (st == AUT) rw = {15'h0000, i_addr[19:12] == PROT_SEC};
    else if (st == SEC) rw = SEC_WORD;
    else if (st == ERS && i_addr[19:12] == esec) rw = STAT_WORD ^ 16'h0044;
    else if (st == SUS && i_addr[19:12] == esec) rw = STAT_WORD;
    else rw = mem[i_addr[7:0]];
  end

  // A released bus shows the inverse of the last word so stale data never passes.
  always @(posedge i_oe_n) last = rw;
  assign o_dq = (!i_ce_n && !i_oe_n) ? rw : ~last;
endmodule : fesc_flash_model
`default_nettype wire

/* File: sim/fesc_host_test.sv */
`timescale 1ns/100ps
`default_nettype none
module fesc_host_test
  import fesc_pkg::*;
;
  localparam logic [15:0] MAKER = 16'h00C5;
  localparam logic [15:0] DEVID = 16'h7E51;
  localparam logic [15:0] SEC_WORD = 16'h5EC0;
  localparam logic [15:0] STAT_WORD = 16'h00A4;
  localparam logic [7:0]  PROT_SEC = 8'h07;
  logic        i_clk, i_rst, i_cmd_valid, i_op_done, o_cmd_ready, o_cmd_err, o_rd_valid;
  logic        o_dq_oe, o_ce_n, o_we_n, o_oe_n, err;
  fesc_cmd_t   i_cmd;
  fesc_mode_t  o_mode;
  logic [19:0] i_addr, o_addr, a;
  logic [15:0] i_data, o_rd_data, o_dq_out, i_dq_in, rd, d;
  logic [7:0]  qoff [5] = '{8'h00, 8'h01, 8'h03, 8'h02, 8'h02};
  logic [15:0] qexp [5] = '{MAKER, DEVID, 16'h0080, 16'h0001, 16'h0000};
  int          fail_count = 0, compares = 0, cycles = 0, waited, k;
  int          seed = 32'h11d3;

  fesc_host DUT (.i_clk(i_clk), .i_rst(i_rst), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
    .i_addr(i_addr), .i_data(i_data), .i_op_done(i_op_done), .o_cmd_ready(o_cmd_ready),
    .o_cmd_err(o_cmd_err), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .o_mode(o_mode),
    .o_addr(o_addr), .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe), .i_dq_in(i_dq_in),
    .o_ce_n(o_ce_n), .o_we_n(o_we_n), .o_oe_n(o_oe_n));
  fesc_flash_model #(.MAKER(MAKER), .DEVID(DEVID), .SEC_WORD(SEC_WORD),
    .STAT_WORD(STAT_WORD), .PROT_SEC(PROT_SEC)) flash (.i_addr(o_addr), .i_dq(o_dq_out),
    .i_ce_n(o_ce_n), .i_we_n(o_we_n), .i_oe_n(o_oe_n), .i_done(i_op_done), .o_dq(i_dq_in));

  task automatic results;
    $display("Mismatches %0d of %0d compares", fail_count, compares);
    if (fail_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic mode(input fesc_mode_t m);
    check("mode", 16'(o_mode), 16'(m));
  endtask : mode

  // Entered just after an edge with the port idle; e is the expected refusal.
  task automatic run(input fesc_cmd_t c, input logic [19:0] ad, input logic [15:0] w,
                     input logic e);
    i_cmd = c;
    i_addr = ad;
    i_data = w;
    i_cmd_valid = 1'b1;
    rd = 'x;
    err = 1'b0;
    waited = 0;
    @(posedge i_clk);
    #1;
    i_cmd_valid = 1'b0;
    // The refusal pulse stands only in the cycle after the request edge.
    if (o_cmd_err === 1'b1) err = 1'b1;
    do begin
      @(posedge i_clk);
      #1;
      if (o_cmd_err === 1'b1) err = 1'b1;
      if (o_rd_valid === 1'b1) rd = o_rd_data;
      waited++;
    end while (o_cmd_ready !== 1'b1 && waited < 3000);
    // A command that never finishes counts as a mismatch.
    if (o_cmd_ready !== 1'b1) fail_count++;
    check("err", {15'h0000, err}, {15'h0000, e});
  endtask : run

  task automatic done;
    i_op_done = 1'b1;
    @(posedge i_clk);
    #1;
    i_op_done = 1'b0;
    @(posedge i_clk);
    #1;
    mode(M_ARRAY);
  endtask : done

  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  // The full run needs under 10000 cycles; the ceiling leaves ample margin.
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles >= 40000) begin
      fail_count++;
      results();
    end
  end

  initial begin
    i_rst = 1'b1;
    i_cmd_valid = 1'b0;
    i_cmd = C_READ;
    i_addr = 20'h00000;
    i_data = 16'h0000;
    i_op_done = 1'b0;
    repeat (3) @(posedge i_clk);
    #1;
    i_rst = 1'b0;
    check("ready", {15'h0000, o_cmd_ready}, 16'h0001);
    mode(M_ARRAY);
    for (k = 0; k < 3; k++) begin
      a = (k == 0) ? 20'hFFFFF : {8'(k), 4'h0, 8'($random(seed))};
      d = 16'($random(seed));
      run(C_PROGRAM, a, d, 1'b0);
      run(C_READ, a, 16'h0000, 1'b0);
      check("prog_rd", rd, d);
    end
    run(C_BYP_PROG, 20'h00000, 16'h0000, 1'b1);
    run(C_BYP_ENTER, 20'h00000, 16'h0000, 1'b0);
    mode(M_BYPASS);
    a = 20'h020AB;
    d = 16'($random(seed));
    run(C_BYP_PROG, a, d, 1'b0);
    run(C_BYP_EXIT, a, 16'h0000, 1'b0);
    mode(M_ARRAY);
    run(C_READ, a, 16'h0000, 1'b0);
    check("byp_rd", rd, d);
    for (k = 0; k < 5; k++) begin
      run(C_AUTOSEL, {(k == 4) ? 8'h08 : PROT_SEC, 4'h0, qoff[k]}, 16'h0000, 1'b0);
      check("ident", rd, qexp[k]);
      run(C_RESET, 20'h00000, 16'h0000, 1'b0);
      mode(M_ARRAY);
    end
    run(C_QUERY, 20'h00000, 16'h0000, 1'b0);
    mode(M_AUTOSEL);
    run(C_QUERY, 20'h00000, 16'h0000, 1'b0);
    run(C_RESET, 20'h00000, 16'h0000, 1'b0);
    run(C_SEC_ENTER, 20'h00000, 16'h0000, 1'b0);
    mode(M_SECURE);
    run(C_QUERY, 20'h00000, 16'h0000, 1'b1);
    run(C_READ, 20'h00010, 16'h0000, 1'b0);
    check("sec_rd", rd, SEC_WORD);
    run(C_SEC_EXIT, 20'h00010, 16'h0000, 1'b0);
    mode(M_ARRAY);
    run(C_SUSPEND, 20'h00000, 16'h0000, 1'b1);
    run(C_RESUME, 20'h00000, 16'h0000, 1'b1);
    run(C_CHIP_ERASE, 20'h00000, 16'h0000, 1'b0);
    mode(M_CHIP);
    run(C_SUSPEND, 20'h00000, 16'h0000, 1'b1);
    mode(M_CHIP);
    done();
    a = 20'h40123;
    run(C_SECT_ERASE, a, 16'h0000, 1'b0);
    mode(M_ERASE);
    run(C_SECT_ADD, 20'h41000, 16'h0000, 1'b0);
    run(C_SUSPEND, a, 16'h0000, 1'b0);
    check("sus_wait", 16'(waited >= 1000), 16'h0001);
    mode(M_SUSP);
    run(C_READ, a, 16'h0000, 1'b0);
    check("sus_stat", rd, STAT_WORD);
    d = 16'($random(seed));
    run(C_PROGRAM, 20'h03077, d, 1'b0);
    mode(M_SUSP);
    run(C_READ, 20'h03077, 16'h0000, 1'b0);
    check("sus_rd", rd, d);
    run(C_AUTOSEL, 20'h00001, 16'h0000, 1'b0);
    check("sus_id", rd, DEVID);
    run(C_RESET, 20'h00000, 16'h0000, 1'b0);
    mode(M_SUSP);
    for (k = 0; k < 2; k++) begin
      run(C_RESUME, a, 16'h0000, 1'b0);
      mode(M_ERASE);
      run(C_RESUME, a, 16'h0000, 1'b1);
      run(C_SUSPEND, a, 16'h0000, 1'b0);
      mode(M_SUSP);
    end
    run(C_RESUME, a, 16'h0000, 1'b0);
    run(C_READ, a, 16'h0000, 1'b0);
    check("ers_stat", rd, STAT_WORD ^ 16'h0044);
    done();
    results();
  end
endmodule : fesc_host_test
`default_nettype wire
